// ---- lcgis_gate_or.sv ----
// Purpose: one gate: OR of four source terms
// Assumes: enables per source in true and inverted form
// Notes:   all enables clear gives constant low
`timescale 1ns/1ps
`default_nettype none
module lcgis_gate_or import lcgis_pkg::*; (
	input  wire logic [3:0] src,
	input  wire logic [3:0] true_en,
	input  wire logic [3:0] inv_en,
	output logic            gate
);
	logic [3:0] term;
	for (genvar i = 0; i < LCGIS_NSRC; i++) begin : g_t
		lcgis_term u_t (
			.src     (src[i]),
			.true_en (true_en[i]),
			.inv_en  (inv_en[i]),
			.term    (term[i])
		);
	end
	assign gate = |term;
endmodule
`default_nettype wire

// ---- lcgis_pkg.sv ----
// Purpose: constants for the logic cell gate input select block
// Assumes: 16-bit select register on a plain strobe port
// Notes:   register offsets are word indices on the plain port
//
// Operation
// - gate2 takes inverted source 4 when enabled
// - gate2 takes true source 3 when enabled
// - gate2 takes inverted source 3 when enabled
// - gate2 takes true source 2 when enabled
// - gate2 takes inverted source 2 when enabled
// - gate2 takes true source 1 when enabled
// - gate2 takes inverted source 1 when enabled
// - gate1 takes true source 4 when enabled
// - gate1 takes inverted source 4 when enabled
// - gate1 takes true source 3 when enabled
package lcgis_pkg;
	localparam int          LCGIS_AW         = 4;
	localparam int          LCGIS_DW         = 16;
	localparam int          LCGIS_NSRC       = 4;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0]  LCGIS_SEL_UPPER_OFS = 4'h0;
	localparam logic [3:0]  LCGIS_STATUS_OFS    = 4'h1;
	localparam logic [15:0] LCGIS_SEL_RESET     = 16'h0000;
	localparam logic [15:0] LCGIS_SEL_WMASK     = 16'h7fe0;
	// ----------------------------------------------------------------
	// field positions in gate_source_select_upper
	// ----------------------------------------------------------------
	localparam int          LCGIS_G2S4_INV   = 14;
	localparam int          LCGIS_G2S3_TRUE  = 13;
	localparam int          LCGIS_G2S3_INV   = 12;
	localparam int          LCGIS_G2S2_TRUE  = 11;
	localparam int          LCGIS_G2S2_INV   = 10;
	localparam int          LCGIS_G2S1_TRUE  = 9;
	localparam int          LCGIS_G2S1_INV   = 8;
	localparam int          LCGIS_G1S4_TRUE  = 7;
	localparam int          LCGIS_G1S4_INV   = 6;
	localparam int          LCGIS_G1S3_TRUE  = 5;
endpackage

// ---- lcgis_term.sv ----
// Purpose: one source term: true and inverted forms, each gated
// Assumes: enables steady from a register
// Notes:   pure combinational
`timescale 1ns/1ps
`default_nettype none
module lcgis_term (
	input  wire logic src,
	input  wire logic true_en,
	input  wire logic inv_en,
	output logic      term
);
	assign term = (src & true_en) | (~src & inv_en);
endmodule
`default_nettype wire

// ---- lcgis_top.sv ----
// Purpose: gate input select register and gate 1/2 input combining
// Assumes: plain register port, read data one cycle after strobe
// Notes:   gate 1 sources 1-2 enables come in as ports from elsewhere
//          gate outputs are combinational; the select register and the read data are registered
//          reserved select bits are masked on write so readback shows zeros
`timescale 1ns/1ps
`default_nettype none
module lcgis_top import lcgis_pkg::*; (
	input  wire logic                clock,
	input  wire logic                sys_rst,
	input  wire logic [LCGIS_AW-1:0] addr,
	input  wire logic [LCGIS_DW-1:0] wdata,
	input  wire logic                wr,
	input  wire logic                rd,
	output logic      [LCGIS_DW-1:0] rdata,
	input  wire logic [3:0]          src,
	input  wire logic [1:0]          gate1_low_true_en,
	input  wire logic [1:0]          gate1_low_inv_en,
	output logic                     gate1,
	output logic                     gate2
);
	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	logic [15:0] sel_r, sel_nxt;
	logic [15:0] rdata_r, rdata_nxt;

	always_comb begin
		sel_nxt   = sel_r;
		rdata_nxt = 16'h0000;
		if (wr && addr == LCGIS_SEL_UPPER_OFS) begin
			// unimplemented bits stay zero so readback is honest
			sel_nxt = wdata & LCGIS_SEL_WMASK;
		end
		if (rd) begin
			case (addr)
				LCGIS_SEL_UPPER_OFS: rdata_nxt = sel_r;
				LCGIS_STATUS_OFS:    rdata_nxt = {14'h0000, gate2, gate1};
				default:             rdata_nxt = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sel_r   <= LCGIS_SEL_RESET;
			rdata_r <= 16'h0000;
		end else begin
			sel_r   <= sel_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	assign rdata = rdata_r;

	// ----------------------------------------------------------------
	// gate enables
	// ----------------------------------------------------------------
	logic [3:0] g1_true, g1_inv, g2_true, g2_inv;
	assign g2_inv  = {sel_r[LCGIS_G2S4_INV], sel_r[LCGIS_G2S3_INV],
	                  sel_r[LCGIS_G2S2_INV], sel_r[LCGIS_G2S1_INV]};
	// gate 2 source 4 true enable lives above this register
	assign g2_true = {1'b0, sel_r[LCGIS_G2S3_TRUE],
	                  sel_r[LCGIS_G2S2_TRUE], sel_r[LCGIS_G2S1_TRUE]};
	assign g1_true = {sel_r[LCGIS_G1S4_TRUE], sel_r[LCGIS_G1S3_TRUE],
	                  gate1_low_true_en};
	// gate 1 source 3 inverted enable not held here
	assign g1_inv  = {sel_r[LCGIS_G1S4_INV], 1'b0, gate1_low_inv_en};

	lcgis_gate_or u_g1 (
		.src     (src),
		.true_en (g1_true),
		.inv_en  (g1_inv),
		.gate    (gate1)
	);
	lcgis_gate_or u_g2 (
		.src     (src),
		.true_en (g2_true),
		.inv_en  (g2_inv),
		.gate    (gate2)
	);

	// ----------------------------------------------------------------
	// named select fields, read by the checks below
	// ----------------------------------------------------------------
	logic       gate2_src4_inv_en;
	logic       gate2_src3_true_en;
	logic       gate2_src3_inv_en;
	logic       gate2_src2_true_en;
	logic       gate2_src2_inv_en;
	logic       gate2_src1_true_en;
	logic       gate2_src1_inv_en;
	logic       gate1_src4_true_en;
	logic       gate1_src4_inv_en;
	logic       gate1_src3_true_en;
	logic [6:0] g2_fields;
	logic [2:0] g1_fields;
	logic       g1_low_quiet;

	assign gate2_src4_inv_en  = sel_r[LCGIS_G2S4_INV];
	assign gate2_src3_true_en = sel_r[LCGIS_G2S3_TRUE];
	assign gate2_src3_inv_en  = sel_r[LCGIS_G2S3_INV];
	assign gate2_src2_true_en = sel_r[LCGIS_G2S2_TRUE];
	assign gate2_src2_inv_en  = sel_r[LCGIS_G2S2_INV];
	assign gate2_src1_true_en = sel_r[LCGIS_G2S1_TRUE];
	assign gate2_src1_inv_en  = sel_r[LCGIS_G2S1_INV];
	assign gate1_src4_true_en = sel_r[LCGIS_G1S4_TRUE];
	assign gate1_src4_inv_en  = sel_r[LCGIS_G1S4_INV];
	assign gate1_src3_true_en = sel_r[LCGIS_G1S3_TRUE];
	assign g2_fields          = sel_r[LCGIS_G2S4_INV:LCGIS_G2S1_INV];
	assign g1_fields          = sel_r[LCGIS_G1S4_TRUE:LCGIS_G1S3_TRUE];
	assign g1_low_quiet       = (gate1_low_true_en == 2'h0) && (gate1_low_inv_en == 2'h0);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_g2_src4_inv: assert property (sel_r[14] && !src[3] |-> gate2)
		else $error("gate2 missing inverted source 4");
	a_g2_src3_true: assert property (sel_r[13] && src[2] |-> gate2)
		else $error("gate2 missing true source 3");
	a_g2_src3_inv: assert property (sel_r[12] && !src[2] |-> gate2)
		else $error("gate2 missing inverted source 3");
	a_g2_src2_true: assert property (sel_r[11] && src[1] |-> gate2)
		else $error("gate2 missing true source 2");
	a_g2_src2_inv: assert property (sel_r[10] && !src[1] |-> gate2)
		else $error("gate2 missing inverted source 2");
	a_g2_src1_true: assert property (sel_r[9] && src[0] |-> gate2)
		else $error("gate2 missing true source 1");
	a_g2_src1_inv: assert property (sel_r[8] && !src[0] |-> gate2)
		else $error("gate2 missing inverted source 1");
	a_g1_src4_true: assert property (sel_r[7] && src[3] |-> gate1)
		else $error("gate1 missing true source 4");
	a_g1_src4_inv: assert property (sel_r[6] && !src[3] |-> gate1)
		else $error("gate1 missing inverted source 4");
	a_g1_src3_true: assert property (sel_r[5] && src[2] |-> gate1)
		else $error("gate1 missing true source 3");
	a_g2_idle_low: assert property (sel_r[14:8] == 7'h00 |-> !gate2)
		else $error("gate2 high with no enables");
	a_write_read: assert property (wr && addr == LCGIS_SEL_UPPER_OFS ##1
		rd && addr == LCGIS_SEL_UPPER_OFS |=> rdata == ($past(wdata, 2) & 16'h7fe0))
		else $error("select readback mismatch");

	// ----------------------------------------------------------------
	// single enable checks: one enable set makes the gate that term
	// ----------------------------------------------------------------
	a_g2s4inv_alone: assert property (
		g2_fields == 7'h40
		|-> gate2 == !src[3])
		else $error("gate2 differs from inverted source 4 alone");

	a_g2s3true_alone: assert property (
		g2_fields == 7'h20
		|-> gate2 == src[2])
		else $error("gate2 differs from true source 3 alone");

	a_g2s3inv_alone: assert property (
		g2_fields == 7'h10
		|-> gate2 == !src[2])
		else $error("gate2 differs from inverted source 3 alone");

	a_g2s2true_alone: assert property (
		g2_fields == 7'h08
		|-> gate2 == src[1])
		else $error("gate2 differs from true source 2 alone");

	a_g2s2inv_alone: assert property (
		g2_fields == 7'h04
		|-> gate2 == !src[1])
		else $error("gate2 differs from inverted source 2 alone");

	a_g2s1true_alone: assert property (
		g2_fields == 7'h02
		|-> gate2 == src[0])
		else $error("gate2 differs from true source 1 alone");

	a_g2s1inv_alone: assert property (
		g2_fields == 7'h01
		|-> gate2 == !src[0])
		else $error("gate2 differs from inverted source 1 alone");

	a_g1s4true_alone: assert property (
		g1_fields == 3'h4 && g1_low_quiet
		|-> gate1 == src[3])
		else $error("gate1 differs from true source 4 alone");

	a_g1s4inv_alone: assert property (
		g1_fields == 3'h2 && g1_low_quiet
		|-> gate1 == !src[3])
		else $error("gate1 differs from inverted source 4 alone");

	a_g1s3true_alone: assert property (
		g1_fields == 3'h1 && g1_low_quiet
		|-> gate1 == src[2])
		else $error("gate1 differs from true source 3 alone");

	// ----------------------------------------------------------------
	// both forms of one source enabled: the term is always on
	// ----------------------------------------------------------------
	a_g2s3_both_on: assert property (
		gate2_src3_true_en && gate2_src3_inv_en
		|-> gate2)
		else $error("gate2 low with both forms of source 3 enabled");

	a_g2s2_both_on: assert property (
		gate2_src2_true_en && gate2_src2_inv_en
		|-> gate2)
		else $error("gate2 low with both forms of source 2 enabled");

	a_g2s1_both_on: assert property (
		gate2_src1_true_en && gate2_src1_inv_en
		|-> gate2)
		else $error("gate2 low with both forms of source 1 enabled");

	a_g1s4_both_on: assert property (
		gate1_src4_true_en && gate1_src4_inv_en
		|-> gate1)
		else $error("gate1 low with both forms of source 4 enabled");

	// ----------------------------------------------------------------
	// exclusion: a gate is high only through an enabled, active term
	// ----------------------------------------------------------------
	a_g2_no_stray: assert property (
		gate2
		|-> (gate2_src4_inv_en && !src[3])
		 || (gate2_src3_true_en && src[2])
		 || (gate2_src3_inv_en && !src[2])
		 || (gate2_src2_true_en && src[1])
		 || (gate2_src2_inv_en && !src[1])
		 || (gate2_src1_true_en && src[0])
		 || (gate2_src1_inv_en && !src[0]))
		else $error("gate2 high with no enabled term active");

	// source 3 inverted form is tied off, so it must never show up here
	a_g1_no_stray: assert property (
		gate1
		|-> (gate1_low_true_en[0] && src[0])
		 || (gate1_low_inv_en[0] && !src[0])
		 || (gate1_low_true_en[1] && src[1])
		 || (gate1_low_inv_en[1] && !src[1])
		 || (gate1_src3_true_en && src[2])
		 || (gate1_src4_true_en && src[3])
		 || (gate1_src4_inv_en && !src[3]))
		else $error("gate1 high with no enabled term active");

	a_g1_idle_low: assert property (
		g1_fields == 3'h0 && g1_low_quiet
		|-> !gate1)
		else $error("gate1 high with no enables");

	// ----------------------------------------------------------------
	// register port checks
	// ----------------------------------------------------------------
	a_reset_clears: assert property (
		disable iff (1'b0)
		sys_rst |=> sel_r == LCGIS_SEL_RESET && rdata == 16'h0000)
		else $error("select or read data not cleared by reset");

	a_reset_g2_low: assert property (
		disable iff (1'b0)
		sys_rst |=> !gate2)
		else $error("gate2 high after reset");

	a_sel_reserved: assert property (
		(sel_r & ~LCGIS_SEL_WMASK) == 16'h0000)
		else $error("reserved select bit set");

	a_sel_write: assert property (
		wr && addr == LCGIS_SEL_UPPER_OFS
		|=> sel_r == ($past(wdata) & LCGIS_SEL_WMASK))
		else $error("select write not taken");

	a_sel_hold: assert property (
		!(wr && addr == LCGIS_SEL_UPPER_OFS)
		|=> $stable(sel_r))
		else $error("select changed without a write");

	a_rd_sel: assert property (
		rd && addr == LCGIS_SEL_UPPER_OFS
		|=> rdata == $past(sel_r))
		else $error("select read data wrong");

	a_rd_status: assert property (
		rd && addr == LCGIS_STATUS_OFS
		|=> rdata == {14'h0000, $past(gate2), $past(gate1)})
		else $error("status read data wrong");

	a_rd_unmapped: assert property (
		rd && addr != LCGIS_SEL_UPPER_OFS && addr != LCGIS_STATUS_OFS
		|=> rdata == 16'h0000)
		else $error("unmapped read not zero");

	// read data is zero outside its one cycle so a bus OR stays clean
	a_rdata_idle: assert property (
		!rd
		|=> rdata == 16'h0000)
		else $error("read data not zero without a read");

	c_g2_high:  cover property (gate2);
	c_g1_high:  cover property (gate1);
	c_both_src: cover property (sel_r[13] && sel_r[12]);
	c_wr_then_rd: cover property (wr ##1 rd);
	c_g1_low_en:  cover property (gate1_low_inv_en != 2'h0 && gate1);
endmodule
`default_nettype wire

// ---- test_logic_cell_gate_input_select.sv ----
// Purpose: self-checking bench for the gate input select block
// Assumes: plain register port, read data one cycle after the strobe
// Notes:   gates compared with an integer model after every change
`timescale 1ns/1ps
`default_nettype none
module test_logic_cell_gate_input_select import lcgis_pkg::*;;
	logic        clock = 0;
	logic        sys_rst = 1;
	logic        wr = 0;
	logic        rd = 0;
	logic [3:0]  addr = 0;
	logic [3:0]  src = 0;
	logic [15:0] wdata = 0;
	logic [15:0] rdata;
	logic [1:0]  lt = 0;
	logic [1:0]  li = 0;
	logic        gate1;
	logic        gate2;
	int          n_errors = 0;
	int          n_tests = 0;
	int          sel = 0;
	int          d;

	lcgis_top i_lcgis_top (.clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .src(src), .gate1_low_true_en(lt),
		.gate1_low_inv_en(li), .gate1(gate1), .gate2(gate2));

	initial begin
		forever #20 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// model: term is true form or inverted form, gates OR their terms
	// ----------------------------------------------------------------
	function automatic int tm(int s, int t, int n);
		return (s & t) | ((1 - s) & n);
	endfunction

	function automatic int model();
		int g1;
		int g2;
		g1 = tm(src[0], lt[0], li[0]) | tm(src[1], lt[1], li[1]) | tm(src[2], sel >> 5 & 1, 0)
			| tm(src[3], sel >> 7 & 1, sel >> 6 & 1);
		g2 = tm(src[0], sel >> 9 & 1, sel >> 8 & 1) | tm(src[1], sel >> 11 & 1, sel >> 10 & 1)
			| tm(src[2], sel >> 13 & 1, sel >> 12 & 1) | tm(src[3], 0, sel >> 14 & 1);
		return g2 * 2 + g1;
	endfunction

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		if (n_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clock);
		wr <= 1;
		addr <= a;
		wdata <= v;
		@(posedge clock);
		wr <= 0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
		@(posedge clock);
		rd <= 1;
		addr <= a;
		@(posedge clock);
		rd <= 0;
		#1;
		chk("rdata", rdata, e);
	endtask

	task automatic gates();
		#1;
		chk("gate1", {15'h0, gate1}, 16'(model() & 1));
		chk("gate2", {15'h0, gate2}, 16'(model() >> 1));
	endtask

	initial begin
		#400000;
		n_errors++;
		results();
	end

	initial begin
		void'($urandom(34782));
		repeat (6) @(posedge clock);
		sys_rst <= 0;
		rd_chk(LCGIS_SEL_UPPER_OFS, 16'h0000);
		// each select register enable alone, under every source pattern
		for (int b = 5; b < 15; b++) begin
			sel = 1 << b;
			wr_reg(LCGIS_SEL_UPPER_OFS, 16'(sel));
			for (int s = 0; s < 16; s++) begin
				@(posedge clock);
				src <= 4'(s);
				gates();
			end
		end
		// random mixes, unwritable bits must read back as zero
		for (int i = 0; i < 60; i++) begin
			d = $urandom;
			@(posedge clock);
			src <= 4'($urandom);
			lt <= 2'($urandom);
			li <= 2'($urandom);
			wr_reg(LCGIS_SEL_UPPER_OFS, 16'(d));
			sel = d & 32'h7fe0;
			gates();
			rd_chk(LCGIS_SEL_UPPER_OFS, 16'(sel));
			rd_chk(LCGIS_STATUS_OFS, 16'(model()));
		end
		// write then read with no gap between the strobes
		for (int i = 0; i < 8; i++) begin
			d = $urandom;
			@(posedge clock);
			wr <= 1;
			addr <= LCGIS_SEL_UPPER_OFS;
			wdata <= 16'(d);
			@(posedge clock);
			wr <= 0;
			rd <= 1;
			@(posedge clock);
			rd <= 0;
			sel = d & 32'h7fe0;
			#1;
			chk("rdata", rdata, 16'(sel));
			gates();
		end
		wr_reg(4'h7, 16'hffff);
		rd_chk(4'h7, 16'h0000);
		rd_chk(LCGIS_SEL_UPPER_OFS, 16'(sel));
		results();
	end
endmodule
`default_nettype wire
